// >>> design/mdsp_cfg.svh
// Summary of operation
// (R1) New-mask mode: RAM data pins at row-strobe fall gate each bit written.
// (R2) Persistent mode: ignore RAM data pins, use the stored mask register.
// (R3) Serial buffer moves data on each serial shift clock rising edge.
// (R4) Serial write: word on serial data pins captured at shift clock rise.
// (R5) Shift port enable low gates serial output and serial write.
// (R6) Serial pointer advances on every shift clock edge, enabled or not; the pointer here advances on rising edges only.
// (R7) Special-function select sampled at row-strobe and column-strobe falls.
// (R8) Split mode: half indicator low for lower half, high for upper.
// (R9) Half indicator driven only while shift port enable is low.
// (R10) Read transfer sets serial output mode; write transfer sets input mode.
// (R11) Operation chosen from strobe and enable levels at both strobe falls.
// (R12) Column-before-row refresh; clear-mask and stop-load variants.
// (R13) Refresh with write enable and select high keeps all settings.
// (R14) Transfer when transfer enable low; write enable picks direction.
// (R15) Select low then high gives block write on column bits 3 to 8.
// (R16) Select high at row-strobe fall decodes special functions only.
// (R17) Write enable low with select high gives masked flash write.
// (R18) Register load: select low loads mask and sets persistent, else color.
// (R19) Stored mask stays in use until a clear-options refresh.
// (R20) Transfer enable low starts transfer, high acts as output enable; here high only marks a non-transfer cycle, as no RAM data is driven.
// (R21) Both write enables high read to buffer, either low writes to RAM.
// (R22) Serial and strobe logic share state safely inside one clock domain.
//
// file holds register offsets, field positions and reset values
// assumes it is included by bare name and only for definitions
`ifndef MDSP_CFG_SVH
`define MDSP_CFG_SVH

// register byte offsets on the bus
`define MDSP_REG_CTRL 8'h00
`define MDSP_REG_STATUS 8'h04
`define MDSP_REG_MASK 8'h08
`define MDSP_REG_COLOR 8'h0C
`define MDSP_REG_STOP 8'h10
`define MDSP_REG_POINTER 8'h14

// control register fields and reset value
`define MDSP_CTRL_DECODE_EN 0
`define MDSP_CTRL_RESET 32'h0000_0001

// status register fields
`define MDSP_ST_MODE_LSB 0
`define MDSP_ST_PERSIST 4
`define MDSP_ST_DIR_OUT 5
`define MDSP_ST_SPLIT 6
`define MDSP_ST_STOP_VALID 7

// reset values of the stored settings
`define MDSP_MASK_RESET 16'hFFFF
`define MDSP_COLOR_RESET 16'h0000

`endif

// >>> design/mdsp_pkg.sv
// file holds the types shared by the serial port and mode decode logic
// assumes the constants header is included where numbers are needed
package mdsp_pkg;

  // decoded operating modes of the ram port
  typedef enum logic [3:0] {
    mdsp_idle,
    refresh_clear_options,
    refresh_set_stop,
    refresh_keep_options,
    row_only_refresh,
    masked_full_write_transfer,
    masked_split_write_transfer,
    full_read_transfer,
    split_read_transfer,
    masked_read_write,
    masked_block_write,
    masked_flash_write,
    read_write,
    unmasked_block_write,
    load_write_mask,
    load_color_value
  } mdsp_mode_e;

  // row-strobe cycle tracker
  typedef enum logic [1:0] {
    ras_idle,
    ras_wait_cas,
    ras_done
  } mdsp_ras_e;

endpackage

// >>> design/mdsp_top.sv
// file holds the mode decoder and serial buffer port of a multiport dram
// assumes all pins arrive asynchronously and the bus is ahb-lite on hclk
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "mdsp_cfg.svh"

module mdsp_top
  import mdsp_pkg::*;
#(
  parameter int SAM_DEPTH = 512,
  parameter int SAM_WIDTH = 16,
  parameter int ADDR_W = 9
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // ram port strobes and controls
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic transfer_output_enable_n,
  input wire logic write_enable_lower_n,
  input wire logic write_enable_upper_n,
  input wire logic special_function_select,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [SAM_WIDTH-1:0] ram_data_pins,
  // decoded operation toward the array
  output mdsp_mode_e op_mode,
  output logic op_pulse,
  output logic [ADDR_W-1:0] op_row,
  output logic [ADDR_W-1:0] op_col,
  output logic [SAM_WIDTH-1:0] op_write_mask,
  output logic [SAM_WIDTH-1:0] color_value,
  // serial port
  input wire logic serial_shift_clock,
  input wire logic shift_port_enable_n,
  input wire logic [SAM_WIDTH-1:0] serial_data_in,
  output logic [SAM_WIDTH-1:0] serial_data_out,
  output logic serial_data_oe,
  output logic split_half_indicator,
  output logic split_half_indicator_oe
);

  localparam int PW = 8 + ADDR_W + 2 * SAM_WIDTH;
  localparam int HB = $clog2(SAM_DEPTH) - 1;

  // pin synchroniser: three stages, filtered value follows when 2 and 3 agree
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] sync1_r;
  logic [PW-1:0] sync2_r;
  logic [PW-1:0] sync3_r;
  logic [PW-1:0] filt_r;
  logic [PW-1:0] filt_prev_r;

  assign pin_raw = {serial_data_in, ram_data_pins, addr, shift_port_enable_n,
                    serial_shift_clock, special_function_select,
                    write_enable_upper_n, write_enable_lower_n,
                    transfer_output_enable_n, cas_n, ras_n};

  // first stage feeds only the second; the filter looks at stages 2 and 3
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= '1;
      sync2_r <= '1;
      sync3_r <= '1;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // per-bit filter and edge history
  genvar gi;
  generate
    for (gi = 0; gi < PW; gi++) begin : g_filt
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          filt_r[gi] <= 1'b1;
          filt_prev_r[gi] <= 1'b1;
        end else begin
          if (sync2_r[gi] == sync3_r[gi]) begin
            filt_r[gi] <= sync3_r[gi];
          end
          filt_prev_r[gi] <= filt_r[gi];
        end
      end
    end
  endgenerate

  // named filtered pin levels
  wire ras_f = filt_r[0];
  wire cas_f = filt_r[1];
  wire trg_f = filt_r[2];
  wire wel_f = filt_r[3];
  wire weu_f = filt_r[4];
  wire dsf_f = filt_r[5];
  wire sc_f = filt_r[6];
  wire se_f = filt_r[7];
  wire [ADDR_W-1:0] addr_f = filt_r[8 +: ADDR_W];
  wire [SAM_WIDTH-1:0] dq_f = filt_r[8 + ADDR_W +: SAM_WIDTH];
  wire [SAM_WIDTH-1:0] sdin_f = filt_r[8 + ADDR_W + SAM_WIDTH +: SAM_WIDTH];

  // edges of the strobes and the serial clock
  wire ras_fall = filt_prev_r[0] & ~ras_f;
  wire ras_rise = ~filt_prev_r[0] & ras_f;
  wire cas_fall = filt_prev_r[1] & ~cas_f;
  wire sc_rise = ~filt_prev_r[6] & sc_f; // [R3]
  wire we_high = wel_f & weu_f; // both write enables high

  // control and stored settings
  logic [31:0] ctrl_r;
  logic [SAM_WIDTH-1:0] mask_reg_r;
  logic [SAM_WIDTH-1:0] color_r;
  logic persist_r;
  logic [ADDR_W-1:0] stop_r;
  logic stop_valid_r;
  logic dir_out_r;
  logic split_r;
  logic [HB:0] ptr_r;

  // latched state of the current row-strobe cycle
  mdsp_ras_e ras_st_r;
  logic trg_ras_r;
  logic we_ras_r;
  logic dsf_ras_r;
  logic [SAM_WIDTH-1:0] mask_ras_r;

  wire decode_en = ctrl_r[`MDSP_CTRL_DECODE_EN];

  // mode chosen at the row-strobe fall for operations complete there
  // refresh decode happens first because a low column strobe overrides all
  mdsp_mode_e ras_mode;
  always_comb begin
    ras_mode = mdsp_idle;
    if (!cas_f) begin
      if (we_high && !dsf_f) begin
        ras_mode = refresh_clear_options; // [R12]
      end else if (!we_high && dsf_f) begin
        ras_mode = refresh_set_stop; // [R12]
      end else begin
        ras_mode = refresh_keep_options; // [R13]
      end
    end else if (trg_f && dsf_f && !we_high) begin
      ras_mode = masked_flash_write; // [R16] [R17]
    end
  end

  // mode chosen at the column-strobe fall; non-transfer modes use both select samples
  mdsp_mode_e cas_mode;
  always_comb begin
    cas_mode = mdsp_idle;
    if (!trg_ras_r) begin
      // transfer: write enable picks direction, select picks split [R20]
      case ({we_ras_r, dsf_ras_r}) // [R14] [R21]
        2'b00: cas_mode = masked_full_write_transfer;
        2'b01: cas_mode = masked_split_write_transfer;
        2'b10: cas_mode = full_read_transfer;
        default: cas_mode = split_read_transfer;
      endcase
    end else if (dsf_ras_r) begin
      cas_mode = dsf_f ? load_color_value : load_write_mask; // [R18]
    end else begin
      case ({we_ras_r, dsf_f}) // [R7] [R15]
        2'b00: cas_mode = masked_read_write;
        2'b01: cas_mode = masked_block_write;
        2'b10: cas_mode = read_write;
        default: cas_mode = unmasked_block_write;
      endcase
    end
  end

  // effective write mask: pins for new mask, register when persistent
  wire [SAM_WIDTH-1:0] mask_sel = persist_r ? mask_reg_r : dq_f; // [R1] [R2]
  wire [SAM_WIDTH-1:0] mask_use = we_high ? '1 : mask_sel;

  // which strobe event ends decoding this cycle
  wire ras_emit = decode_en && ras_fall && (ras_mode != mdsp_idle);
  wire cas_emit = decode_en && cas_fall && (ras_st_r == ras_wait_cas);
  // no column strobe in a plain cycle means a row-only refresh
  wire ror_emit = decode_en && ras_rise && (ras_st_r == ras_wait_cas) &&
                  trg_ras_r && !dsf_ras_r;
  wire emit = ras_emit | cas_emit | ror_emit;
  mdsp_mode_e emit_mode;
  assign emit_mode = ras_emit ? ras_mode :
                     (cas_emit ? cas_mode : row_only_refresh); // [R11]

  // row-strobe cycle tracker and latched samples
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ras_st_r <= ras_idle;
      trg_ras_r <= 1'b1;
      we_ras_r <= 1'b1;
      dsf_ras_r <= 1'b0;
      mask_ras_r <= '1;
    end else begin
      case (ras_st_r)
        ras_idle: begin
          if (decode_en && ras_fall) begin
            trg_ras_r <= trg_f;
            we_ras_r <= we_high;
            dsf_ras_r <= dsf_f; // [R7]
            mask_ras_r <= mask_use;
            ras_st_r <= (ras_mode == mdsp_idle) ? ras_wait_cas : ras_done;
          end
        end
        ras_wait_cas: begin
          if (cas_fall) begin
            ras_st_r <= ras_done;
          end else if (ras_rise) begin
            ras_st_r <= ras_idle;
          end
        end
        ras_done: begin
          if (ras_rise) begin
            ras_st_r <= ras_idle;
          end
        end
        default: ras_st_r <= ras_idle;
      endcase
    end
  end

  // operation outputs toward the array
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_mode <= mdsp_idle;
      op_pulse <= 1'b0;
      op_row <= '0;
      op_col <= '0;
      op_write_mask <= '1;
    end else begin
      op_pulse <= emit;
      if (decode_en && ras_fall) begin
        op_row <= addr_f;
        op_write_mask <= mask_use; // [R1] [R2] [R19]
      end
      if (emit) begin
        op_mode <= emit_mode;
      end
      if (cas_emit) begin
        // block write leaves the low three column bits to the device
        op_col <= (cas_mode == masked_block_write ||
                   cas_mode == unmasked_block_write) ?
                  {addr_f[ADDR_W-1:3], 3'h0} : addr_f; // [R15]
      end
    end
  end

  // stored mask, color, persistent flag and stop register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_reg_r <= `MDSP_MASK_RESET;
      color_r <= `MDSP_COLOR_RESET;
      persist_r <= 1'b0;
      stop_r <= '0;
      stop_valid_r <= 1'b0;
    end else if (emit) begin
      case (emit_mode)
        refresh_clear_options: begin
          persist_r <= 1'b0; // [R12] [R19]
          stop_valid_r <= 1'b0;
        end
        refresh_set_stop: begin
          stop_r <= addr_f; // [R12]
          stop_valid_r <= 1'b1;
        end
        load_write_mask: begin
          mask_reg_r <= dq_f; // [R18]
          persist_r <= 1'b1;
        end
        load_color_value: color_r <= dq_f; // [R18]
        default: ; // keep-options refresh changes nothing [R13]
      endcase
    end
  end

  assign color_value = color_r;

  // serial pointer: split mode hops halves at a half end or stop point
  wire half_end = &ptr_r[HB-1:0];
  wire stop_hit = stop_valid_r && (ptr_r[HB-1:0] == stop_r[HB-1:0]);
  wire [HB:0] ptr_inc = ptr_r + 1'b1;
  wire [HB:0] ptr_nxt = (split_r && (half_end || stop_hit)) ?
                        {~ptr_r[HB], {HB{1'b0}}} : ptr_inc;
  wire is_xfer = cas_emit && !trg_ras_r;
  wire xfer_read = we_ras_r;
  wire xfer_split = dsf_ras_r;

  // transfers take precedence over a shift edge in the same cycle
  // state shared by both sides lives here, in one domain [R22]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ptr_r <= '0;
      dir_out_r <= 1'b1;
      split_r <= 1'b0;
    end else if (is_xfer) begin
      dir_out_r <= xfer_read; // [R10]
      split_r <= xfer_split;
      if (!xfer_split) begin
        ptr_r <= addr_f[HB:0]; // tap from the column strobe [R14]
      end
    end else if (sc_rise) begin
      ptr_r <= ptr_nxt; // advances even when disabled [R6]
    end
  end

  // serial buffer storage, no reset needed for data
  logic [SAM_WIDTH-1:0] sam_mem [SAM_DEPTH];
  always_ff @(posedge hclk) begin
    if (sc_rise && !se_f && !dir_out_r) begin
      sam_mem[ptr_r] <= sdin_f; // [R3] [R4] [R5]
    end
  end

  // serial output word, output enable and half indicator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_data_out <= '0;
      serial_data_oe <= 1'b0;
      split_half_indicator <= 1'b0;
      split_half_indicator_oe <= 1'b0;
    end else begin
      if (sc_rise && !se_f && dir_out_r) begin
        serial_data_out <= sam_mem[ptr_r]; // [R3]
      end
      serial_data_oe <= dir_out_r && !se_f; // [R5] [R10]
      split_half_indicator <= ptr_r[HB]; // [R8]
      split_half_indicator_oe <= !se_f; // [R9]
    end
  end

  // ahb-lite slave: zero wait states, always okay
  wire addr_phase = hsel && htrans[1] && hready;
  wire [7:0] rd_sel = haddr[7:0];
  logic wr_pend_r;
  logic [7:0] wr_addr_r;

  wire [31:0] status_word = {24'h0, stop_valid_r, split_r, dir_out_r,
                             persist_r, op_mode};
  wire [31:0] rd_data =
    (rd_sel == `MDSP_REG_CTRL) ? ctrl_r :
    (rd_sel == `MDSP_REG_STATUS) ? status_word :
    (rd_sel == `MDSP_REG_MASK) ? {16'h0, mask_reg_r} :
    (rd_sel == `MDSP_REG_COLOR) ? {16'h0, color_r} :
    (rd_sel == `MDSP_REG_STOP) ? {23'h0, stop_r} :
    (rd_sel == `MDSP_REG_POINTER) ? {23'h0, ptr_r} : 32'h0;

  // read data is captured in the address phase so it comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_addr_r <= rd_sel;
      end
      if (addr_phase && !hwrite) begin
        hrdata <= rd_data;
      end
    end
  end

  // only the control register is writable; others ignore writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `MDSP_CTRL_RESET;
    end else if (wr_pend_r && wr_addr_r == `MDSP_REG_CTRL) begin
      ctrl_r <= {31'h0, hwdata[`MDSP_CTRL_DECODE_EN]};
    end
  end

endmodule // mdsp_top

// >>> verif/mdsp_chk_asserts.sv
// checker: decode and serial port relations seen at the top ports
// assumes pins pass a filter of about five hclk cycles
`timescale 1ns/1ps

module mdsp_chk
  import mdsp_pkg::*;
#(
  parameter int SAM_WIDTH = 16,
  parameter int ADDR_W = 9
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // watched ports
  input wire logic shift_port_enable_n,
  input wire mdsp_mode_e op_mode,
  input wire logic op_pulse,
  input wire logic [ADDR_W-1:0] op_col,
  input wire logic [SAM_WIDTH-1:0] op_write_mask,
  input wire logic [SAM_WIDTH-1:0] color_value,
  input wire logic [SAM_WIDTH-1:0] serial_data_out,
  input wire logic serial_data_oe,
  input wire logic split_half_indicator_oe
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // eight cycles covers the pin filter with margin
  property p_oe_off;
    shift_port_enable_n [*8] |-> !split_half_indicator_oe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("indicator driven while disabled");
  property p_oe_on;
    !shift_port_enable_n [*8] |-> split_half_indicator_oe;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("indicator not driven");
  property p_color;
    $changed(color_value) |-> ##[0:1] op_mode == load_color_value;
  endproperty
  a_color: assert property (p_color)
    else $error("color changed outside a color load");
  property p_chg;
    $changed(op_mode) |-> op_pulse;
  endproperty
  a_chg: assert property (p_chg)
    else $error("mode changed without pulse");
  property p_pulse;
    op_pulse |=> !op_pulse;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("pulse longer than one cycle");
  property p_blk;
    op_pulse && (op_mode == masked_block_write ||
      op_mode == unmasked_block_write) |-> op_col[2:0] == 3'h0;
  endproperty
  a_blk: assert property (p_blk)
    else $error("block column low bits not zero");
  property p_nomask;
    op_pulse && (op_mode == full_read_transfer ||
      op_mode == split_read_transfer) |-> op_write_mask == '1;
  endproperty
  a_nomask: assert property (p_nomask)
    else $error("read transfer carries a mask");
  property p_wdir;
    op_pulse && (op_mode == masked_full_write_transfer ||
      op_mode == masked_split_write_transfer) |-> ##[0:3] !serial_data_oe;
  endproperty
  a_wdir: assert property (p_wdir)
    else $error("write transfer left output mode");
  property p_rdir;
    op_pulse && op_mode == full_read_transfer && !shift_port_enable_n
      |-> ##[0:3] serial_data_oe;
  endproperty
  a_rdir: assert property (p_rdir)
    else $error("read transfer not in output mode");
  // an idle enable must freeze the serial output word
  property p_sdo;
    shift_port_enable_n [*8] |=> $stable(serial_data_out);
  endproperty
  a_sdo: assert property (p_sdo)
    else $error("serial output moved while disabled");

  // main scenarios
  c_flash: cover property (op_pulse && op_mode == masked_flash_write);
  c_rt: cover property (op_pulse && op_mode == full_read_transfer);
  c_color: cover property (op_pulse && op_mode == load_color_value);
endmodule // mdsp_chk

bind mdsp_top mdsp_chk #(.SAM_WIDTH(SAM_WIDTH), .ADDR_W(ADDR_W)) chk_u (
  .hclk(hclk),
  .hresetn(hresetn),
  .shift_port_enable_n(shift_port_enable_n),
  .op_mode(op_mode),
  .op_pulse(op_pulse),
  .op_col(op_col),
  .op_write_mask(op_write_mask),
  .color_value(color_value),
  .serial_data_out(serial_data_out),
  .serial_data_oe(serial_data_oe),
  .split_half_indicator_oe(split_half_indicator_oe)
);

// >>> verif/mdsp_ctl_model.sv
// controller model: drives the ram strobes and the serial port pins
// assumes the device hclk; pins change just after its rising edge
`timescale 1ns/1ps

module mdsp_ctl_model #(
  parameter int AW = 9,
  parameter int DW = 16
) (
  // clock
  input wire logic hclk,
  // ram port
  output logic ras_n,
  output logic cas_n,
  output logic transfer_output_enable_n,
  output logic write_enable_lower_n,
  output logic write_enable_upper_n,
  output logic special_function_select,
  output logic [AW-1:0] addr,
  output logic [DW-1:0] ram_data_pins,
  // serial port
  output logic serial_shift_clock,
  output logic shift_port_enable_n,
  output logic [DW-1:0] serial_data_in
);
  // strobes idle high, serial clock stands low between bursts
  initial begin
    ras_n = 1'b1;
    cas_n = 1'b1;
    transfer_output_enable_n = 1'b1;
    write_enable_lower_n = 1'b1;
    write_enable_upper_n = 1'b1;
    special_function_select = 1'b0;
    addr = '0;
    ram_data_pins = '0;
    serial_shift_clock = 1'b0;
    shift_port_enable_n = 1'b1;
    serial_data_in = '0;
  end

  task automatic w(input int k);
    repeat (k) @(posedge hclk);
  endtask

  // one ram cycle; cm 0 no column strobe, 1 after row, 2 before row
  task automatic cyc(input int cm, input logic x, input logic [1:0] we,
    input logic fr, fc, input logic [AW-1:0] ra, ca,
    input logic [DW-1:0] dq);
    w(1);
    transfer_output_enable_n <= x;
    {write_enable_upper_n, write_enable_lower_n} <= we;
    special_function_select <= fr;
    addr <= ra;
    ram_data_pins <= dq;
    if (cm == 2) begin
      w(8);
      cas_n <= 1'b0;
    end
    w(8);
    ras_n <= 1'b0;
    w(8);
    addr <= ca;
    special_function_select <= fc;
    w(8);
    if (cm == 1) begin
      cas_n <= 1'b0;
    end
    w(8);
    ras_n <= 1'b1;
    cas_n <= 1'b1;
    w(8);
    // released lines must not keep their last value
    addr <= ~ca;
    ram_data_pins <= ~dq;
    w(8);
  endtask

  // n serial clock rises at 400 ns, word held for the whole burst
  task automatic shift(input int n, input logic en_n, input logic [DW-1:0] d);
    w(1);
    shift_port_enable_n <= en_n;
    serial_data_in <= d;
    repeat (n) begin
      w(4);
      serial_shift_clock <= 1'b1;
      w(4);
      serial_shift_clock <= 1'b0;
    end
    w(6);
    serial_data_in <= ~d;
  endtask
endmodule // mdsp_ctl_model

// >>> verif/tb_top.sv
// bench: ahb-lite register access plus strobe and serial sequences
// assumes the controller model stands in for the external controller
`timescale 1ns/1ps
`include "mdsp_cfg.svh"

module tb_top;
  import mdsp_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, op_pulse;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire logic hready;
  logic ras_n, cas_n, transfer_output_enable_n, write_enable_lower_n;
  logic write_enable_upper_n, special_function_select, serial_shift_clock;
  logic shift_port_enable_n, serial_data_oe, split_half_indicator;
  logic split_half_indicator_oe;
  logic [8:0] addr, op_row, op_col;
  logic [15:0] ram_data_pins, op_write_mask, color_value;
  logic [15:0] serial_data_in, serial_data_out;
  mdsp_mode_e op_mode;
  int fail_count = 0;
  int total_checks = 0;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;
  mdsp_top dut_u (.*);
  mdsp_ctl_model ctl_u (.*);

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one single-word transfer; write data goes out in the data phase
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    // only the watchdog ends a wait that never sees ready
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(d & m, e);
    chk(32'(hresp), 32'h0);
  endtask

  // ram cycle through the model, then the decoded mode
  task automatic m(input int cm, input logic x, input logic [1:0] we,
    input logic fr, fc, input logic [8:0] ra, ca, input logic [15:0] dq,
    input mdsp_mode_e e);
    ctl_u.cyc(cm, x, we, fr, fc, ra, ca, dq);
    chk(32'(op_mode), 32'(e));
  endtask

  task automatic print_verdict;
    $display("checks=%0d fails=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog: the sequence needs well under 4000 cycles
  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    ctl_u.w(5);
    rc(`MDSP_REG_CTRL, '1, `MDSP_CTRL_RESET);
    wr(`MDSP_REG_MASK, 32'h1234);
    rc(`MDSP_REG_MASK, '1, 32'(`MDSP_MASK_RESET));
    rc(8'h20, '1, 32'h0);
    m(1, 1, 2'b11, 1, 1, 9'h005, 9'h0, 16'hA5C3, load_color_value);
    chk(32'(color_value), 32'hA5C3);
    m(1, 1, 2'b00, 0, 0, 9'h011, 9'h022, 16'h1234, masked_read_write);
    chk(32'(op_write_mask), 32'h1234);
    chk(32'(op_col), 32'h022);
    m(1, 1, 2'b11, 1, 0, 9'h006, 9'h0, 16'h0F0F, load_write_mask);
    rc(`MDSP_REG_STATUS, 32'h10, 32'h10);
    m(1, 1, 2'b01, 0, 1, 9'h012, 9'h1FF, 16'hFFFF, masked_block_write);
    chk(32'(op_col), 32'h1F8);
    chk(32'(op_write_mask), 32'h0F0F);
    m(2, 1, 2'b11, 1, 0, 9'h0, 9'h0, 16'h0, refresh_keep_options);
    rc(`MDSP_REG_MASK, '1, 32'h0F0F);
    rc(`MDSP_REG_STATUS, 32'h10, 32'h10);
    m(2, 1, 2'b00, 1, 0, 9'h123, 9'h0, 16'h0, refresh_set_stop);
    rc(`MDSP_REG_STOP, '1, 32'h123);
    m(2, 1, 2'b11, 0, 0, 9'h0, 9'h0, 16'h0, refresh_clear_options);
    rc(`MDSP_REG_STATUS, 32'h90, 32'h0);
    m(1, 1, 2'b10, 0, 0, 9'h013, 9'h030, 16'h00FF, masked_read_write);
    chk(32'(op_write_mask), 32'h00FF);
    m(0, 1, 2'b00, 1, 1, 9'h014, 9'h0, 16'h3C3C, masked_flash_write);
    chk(32'(op_write_mask), 32'h3C3C);
    m(0, 1, 2'b11, 0, 0, 9'h0AB, 9'h0, 16'h0, row_only_refresh);
    chk(32'(op_row), 32'h0AB);
    m(1, 1, 2'b11, 0, 0, 9'h015, 9'h031, 16'h0, read_write);
    chk(32'(op_write_mask), 32'hFFFF);
    m(1, 1, 2'b11, 0, 1, 9'h016, 9'h0FF, 16'h0, unmasked_block_write);
    chk(32'(op_col), 32'h0F8);
    m(1, 0, 2'b00, 1, 0, 9'h017, 9'h0, 16'hFFFF,
      masked_split_write_transfer);
    rc(`MDSP_REG_STATUS, 32'h60, 32'h40);
    ctl_u.shift(0, 1'b0, 16'h0);
    m(1, 0, 2'b11, 0, 0, 9'h040, 9'h0FE, 16'h0, full_read_transfer);
    chk(32'(serial_data_oe), 32'h1);
    rc(`MDSP_REG_POINTER, '1, 32'h0FE);
    ctl_u.shift(3, 1'b1, 16'h0);
    rc(`MDSP_REG_POINTER, '1, 32'h101);
    chk(32'(split_half_indicator_oe), 32'h0);
    m(1, 0, 2'b11, 1, 0, 9'h041, 9'h0, 16'h0, split_read_transfer);
    rc(`MDSP_REG_STATUS, 32'h40, 32'h40);
    ctl_u.shift(0, 1'b0, 16'h0);
    ctl_u.w(8);
    chk(32'(split_half_indicator), 32'h1);
    chk(32'(split_half_indicator_oe), 32'h1);
    m(1, 0, 2'b00, 0, 0, 9'h042, 9'h010, 16'hFFFF,
      masked_full_write_transfer);
    chk(32'(serial_data_oe), 32'h0);
    ctl_u.shift(1, 1'b0, 16'hBEEF);
    ctl_u.shift(1, 1'b1, 16'h1111);
    m(1, 0, 2'b11, 0, 0, 9'h043, 9'h010, 16'h0, full_read_transfer);
    chk(32'(split_half_indicator), 32'h0);
    ctl_u.shift(1, 1'b0, 16'h0);
    chk(32'(serial_data_out), 32'hBEEF);
    ctl_u.shift(1, 1'b1, 16'h0);
    chk(32'(serial_data_out), 32'hBEEF);
    // decode disabled: a color load must leave everything alone
    wr(`MDSP_REG_CTRL, 32'h0);
    m(1, 1, 2'b11, 1, 1, 9'h007, 9'h0, 16'h5555, full_read_transfer);
    chk(32'(color_value), 32'hA5C3);
    wr(`MDSP_REG_CTRL, 32'h1);
    print_verdict();
  end
endmodule // tb_top
